// ===== bench/cei_interlock_checker.sv
`timescale 1ns/1ps
module cei_interlock_checker
  import cei_pkg::*;
(
  input logic CLK,
  input logic RST,
  input logic CE,
  input logic ISS_VALID,
  input logic ISS_READY,
  input logic [NSTG-1:0] STG_VALID,
  input logic [NSTG-1:0] STG_HOLD,
  input logic [NSTG-1:0] OP_FIRE,
  input logic [NSTG-1:0] OP_KILL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_take_enters: assert property (
    CE && ISS_VALID && ISS_READY |=> STG_VALID[0]) else $error("lost issue");
  a_fire_has_entry: assert property (
    $past(CE) |-> ((OP_FIRE | OP_KILL) & ~$past(STG_VALID)) == 0)
    else $error("ghost op");
  a_unheld_moves: assert property (
    $past(CE) |-> ($past(STG_VALID & ~STG_HOLD) & ~(OP_FIRE | OP_KILL)) == 0)
    else $error("entry did not advance");
  a_held_silent: assert property (
    $past(CE) |-> ((OP_FIRE | OP_KILL) & $past(STG_HOLD)) == 0)
    else $error("held op fired");
  a_hold_younger: assert property (
    ((STG_HOLD >> 1) & STG_VALID & ~STG_HOLD) == 0) else $error("younger ran");
  a_tail_free: assert property (
    STG_HOLD[S_W:S_X] == 2'h0) else $error("older stage held");
  a_no_decode_kill: assert property (
    !OP_KILL[S_D]) else $error("decode killed");
  a_fire_kill_excl: assert property (
    (OP_FIRE & OP_KILL) == 0) else $error("fire and kill together");
endmodule
bind cei_interlock cei_interlock_checker i_chk (.CLK, .RST, .CE, .ISS_VALID,
  .ISS_READY, .STG_VALID, .STG_HOLD, .OP_FIRE, .OP_KILL);

// ===== bench/conditional_exec_interlock_bench.sv
`timescale 1ns/1ps
module conditional_exec_interlock_bench;
  import cei_pkg::*;
  logic CLK = 0, RST = 1, CE = 1, ISS_VALID = 0, ISS_XW_VALID = 0;
  logic ISS_ADW_VALID = 0, ISS_READY, COND_STROBE, COND_VALUE, hold_o = 0;
  logic [TAGW-1:0] ISS_TAG = '0, COND_TAG;
  logic [2:0] ISS_KIND = '0;
  logic [REGW-1:0] ISS_CREG = 4'h3, ISS_XW_REG = 4'h3, ISS_ADW_REG = 4'h3;
  logic [NSTG-1:0] COND_TRUE = '0, STG_VALID, STG_HOLD, OP_FIRE, OP_KILL;
  logic [NSTG*TAGW-1:0] OP_TAG;
  logic [31:0] rnd = 32'h0001_7CD7;
  logic [NSTG-1:0] frz_v;
  logic ce_d = 1;
  int n_fail = 0, n_tests = 0, n_take = 0, n_done = 0;
  always #10 CLK = ~CLK;
  cei_interlock i_dut (.CLK, .RST, .CE, .ISS_VALID, .ISS_TAG, .ISS_KIND,
    .ISS_CREG, .ISS_XW_VALID, .ISS_XW_REG, .ISS_ADW_VALID, .ISS_ADW_REG,
    .COND_TRUE, .ISS_READY, .STG_VALID, .STG_HOLD, .OP_FIRE, .OP_KILL,
    .OP_TAG, .COND_STROBE, .COND_VALUE, .COND_TAG);
  always @(posedge CLK) begin
    if (!RST && CE && ISS_VALID && ISS_READY) n_take++;
    // A frozen clock enable keeps a pulse standing; count it only once.
    if (!RST && ce_d && (OP_FIRE[S_W] || OP_KILL[S_W])) n_done++;
    ce_d = CE;
  end
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Cycle after issue in which the sample is reported, with no stall.
  function automatic int xst(int k);
    case (k)
      1, 4: return 6;
      2: return 3;
      3, 5: return 7;
      default: return 0;
    endcase
  endfunction
  function automatic int xkill(int k, int c);
    if (c != 0) return 0;
    case (k)
      2: return 7'h7E;
      3: return 7'h20;
      4: return 7'h40;
      default: return 0;
    endcase
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic issue(int k, int t, int xw, int adw);
    ISS_VALID = 1;
    ISS_KIND = 3'(k);
    ISS_TAG = 4'(t);
    ISS_XW_VALID = xw[0];
    ISS_ADW_VALID = adw[0];
    while (!ISS_READY) @(negedge CLK);
    @(negedge CLK);
  endtask
  task automatic run(int ka, int xa, int kb, int ab, int c, int lat);
    int n, gl, sc;
    logic sv;
    logic [NSTG-1:0] km;
    n = 1;
    gl = 0;
    sc = 0;
    sv = 0;
    km = '0;
    COND_TRUE = {NSTG{c[0]}};
    issue(ka, 1, xa, 0);
    issue(kb, 2, 0, ab);
    ISS_VALID = 0;
    while (gl == 0 && n < 30) begin
      for (int k = 0; k < NSTG; k++)
        if (OP_KILL[k] && OP_TAG[TAGW*k+:TAGW] == 4'h2) km[k] = 1;
      if (COND_STROBE && COND_TAG == 4'h2) begin
        sc = n;
        sv = COND_VALUE;
      end
      if (OP_TAG[TAGW*S_W+:TAGW] == 4'h2 && (OP_FIRE[S_W] || OP_KILL[S_W]))
        gl = n;
      @(negedge CLK);
      n++;
    end
    chk(gl, lat);
    chk(km, xkill(kb, c));
    if (ka == 0 && xa == 0) begin
      chk(sc, xst(kb));
      chk(sv, (kb != 0) ? c[0] : 1'b0);
    end
  endtask
  initial begin
    repeat (20) @(negedge CLK);
    RST = 0;
    for (int c = 0; c < 2; c++)
      for (int k = 0; k < 6; k++)
        run(0, 0, k, 0, c, 8);
    run(0, 1, 1, 0, 1, 9);
    run(0, 1, 2, 0, 1, 12);
    run(0, 1, 3, 0, 1, 8);
    run(4, 0, 0, 1, 0, 10);
    issue(0, 5, 0, 0);
    ISS_VALID = 0;
    CE = 0;
    frz_v = STG_VALID;
    repeat (3) @(negedge CLK);
    chk(STG_VALID, frz_v);
    CE = 1;
    repeat (400) begin
      rnd = lfsr(rnd);
      if (!hold_o) begin
        {ISS_VALID, ISS_XW_VALID, ISS_ADW_VALID} = rnd[2:0];
        ISS_KIND = 3'(rnd[5:3] % 6);
        {ISS_TAG, ISS_CREG, ISS_XW_REG, ISS_ADW_REG} = {rnd[15:6], 6'h00};
        COND_TRUE = rnd[22:16];
      end
      hold_o = ISS_VALID && !ISS_READY;
      @(negedge CLK);
    end
    ISS_VALID = 0;
    repeat (40) @(negedge CLK);
    chk(n_done, n_take);
    ISS_VALID = 1;
    repeat (3) @(negedge CLK);
    ISS_VALID = 0;
    RST = 1;
    @(negedge CLK);
    RST = 0;
    chk({ISS_READY, STG_VALID}, 8'h80);
    end_of_test();
  end
  initial begin
    #(20 * 4000);
    n_fail++;
    end_of_test();
  end
endmodule

// ===== src/cei_hazard.sv
`timescale 1ns/1ps
module cei_hazard
  import cei_pkg::*;
(
  cei_stg_if.mon s
);

  logic [NSTG-1:0] stall;
  cei_ent_t er;
  cei_ent_t ea;

  always_comb begin
    stall = '0;
    er = s.ent[S_R];
    ea = s.ent[S_AD];
    // Read-stage test right behind an execute-stage write.
    if (er.v && (er.kind == K_COND_R || er.kind == K_PART_WR) &&
        s.ent[S_X].v && s.ent[S_X].xw_v && s.ent[S_X].xw == er.creg) begin
      stall[S_R] = 1'b1; // see (RQ1) (RQ4) (RQ6)
    end
    // Whole-instruction test waits until no older writer is short of W.
    if (ea.v && ea.kind == K_WHOLE) begin
      for (int k = S_AC1; k <= S_X; k++) begin
        if (s.ent[k].v && s.ent[k].xw_v && s.ent[k].xw == ea.creg) begin
          stall[S_AD] = 1'b1; // see (RQ8)
        end
      end
    end
    // An AD-stage update waits for an older read-stage guard test. Once the
    // guard is in R the prefetched value lets both share the cycle.
    if (ea.v && ea.adw_v) begin
      for (int k = S_AC1; k <= S_AC2; k++) begin
        if (s.ent[k].v && s.ent[k].kind == K_PART_WR &&
            s.ent[k].creg == ea.adw) begin
          stall[S_AD] = 1'b1; // see (RQ13) (RQ14)
        end
      end
    end
    // Partial guards tested in X never need a stall. see (RQ12)
    // A stalled stage holds itself and everything younger. see (RQ17)
    for (int k = 0; k < NSTG; k++) begin
      s.hold[k] = |(stall >> k);
    end
  end

endmodule

// ===== src/cei_interlock.sv
`timescale 1ns/1ps
// Summary of operation
// (RQ1) Plain conditions are sampled in the read stage.
// (RQ2) Whole-instruction guard samples in the address stage.
// (RQ3) Partial guard samples in the execute stage.
// (RQ4) Partial guard on memory write samples in read.
// (RQ5) Conditional single repeat samples in execute stage.
// (RQ6) Read test after execute write stalls one cycle.
// (RQ7) Whole guard true runs AD to W, else nothing.
// (RQ8) Whole guard after execute write stalls four cycles.
// (RQ9) Partial guard gates only the execute operation.
// (RQ10) Partial guard lets AD to R operations run.
// (RQ11) False partial guard drops loaded data.
// (RQ12) Partial guard after execute write never stalls.
// (RQ13) AD write after write-guard test delays two cycles.
// (RQ14) Read test and AD write may share a cycle.
// (RQ15) Guarded write: pointer update always, store only if true.
// (RQ16) Instructions advance one stage per cycle through seven.
// (RQ17) Stall holds the instruction and younger ones only.
module cei_interlock
  import cei_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic ISS_VALID,
  input wire logic [TAGW-1:0] ISS_TAG,
  input wire logic [2:0] ISS_KIND,
  input wire logic [REGW-1:0] ISS_CREG,
  input wire logic ISS_XW_VALID,
  input wire logic [REGW-1:0] ISS_XW_REG,
  input wire logic ISS_ADW_VALID,
  input wire logic [REGW-1:0] ISS_ADW_REG,
  input wire logic [NSTG-1:0] COND_TRUE,
  output logic ISS_READY,
  output logic [NSTG-1:0] STG_VALID,
  output logic [NSTG-1:0] STG_HOLD,
  output logic [NSTG-1:0] OP_FIRE,
  output logic [NSTG-1:0] OP_KILL,
  output logic [NSTG*TAGW-1:0] OP_TAG,
  output logic COND_STROBE,
  output logic COND_VALUE,
  output logic [TAGW-1:0] COND_TAG
);

  typedef struct packed {
    cei_pipe_t ent;
    logic [NSTG-1:0] hold;
    logic ready;
    logic [NSTG-1:0] fire;
    logic [NSTG-1:0] kill;
    logic [NSTG*TAGW-1:0] ftag;
    logic cstb;
    logic cval;
    logic [TAGW-1:0] ctag;
  } cei_state_t;

  cei_state_t st_r;
  cei_state_t st_nxt;
  cei_pipe_t upd;
  cei_ent_t ne;

  cei_stg_if hz_if ();

  cei_hazard u_hazard (
    .s(hz_if.mon)
  );

  assign hz_if.ent = st_nxt.ent;

  // Whether the operation of stage k takes effect, given the condition.
  function automatic logic op_effect(cei_ent_t e, int k);
    logic r;
    r = 1'b1;
    unique case (e.kind)
      K_WHOLE: r = (k == S_D) ? 1'b1 : e.cok; // see (RQ7)
      K_PART: r = (k == S_X) ? e.cok : 1'b1; // see (RQ9) (RQ10) (RQ11)
      K_PART_WR: r = (k == S_W) ? e.cok : 1'b1; // see (RQ15) (RQ10)
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  always_comb begin
    st_nxt = st_r;
    st_nxt.cstb = 1'b0;
    st_nxt.cval = st_r.cval;
    st_nxt.ctag = st_r.ctag;
    st_nxt.fire = '0;
    st_nxt.kill = '0;
    st_nxt.ftag = '0;
    ne = ENT_RST;

    // Capture the condition of an instruction that completes its
    // sampling stage this cycle. A held instruction does not sample until released,
    // so the value it sees is the one after the interlock.
    for (int k = 0; k < NSTG; k++) begin
      upd[k] = st_r.ent[k];
      if (st_r.ent[k].v && !st_r.hold[k] && !st_r.ent[k].cdone &&
          eval_stage(st_r.ent[k].kind) == k) begin
        upd[k].cdone = 1'b1; // see (RQ1) (RQ2) (RQ3) (RQ4) (RQ5)
        upd[k].cok = COND_TRUE[k];
        st_nxt.cstb = 1'b1;
        st_nxt.cval = COND_TRUE[k];
        st_nxt.ctag = st_r.ent[k].tag;
      end
    end

    // Report which stage operations completed, with or without effect.
    for (int k = 0; k < NSTG; k++) begin
      if (upd[k].v && !st_r.hold[k]) begin
        st_nxt.fire[k] = op_effect(upd[k], k);
        st_nxt.kill[k] = !op_effect(upd[k], k);
        st_nxt.ftag[k*TAGW +: TAGW] = upd[k].tag;
      end
    end

    // Advance one stage per cycle; a held stage keeps its entry and the
    // first stage in front of it receives a bubble. see (RQ16) (RQ17)
    for (int k = 1; k < NSTG; k++) begin
      if (st_r.hold[k]) begin
        st_nxt.ent[k] = upd[k];
      end else if (st_r.hold[k-1]) begin
        st_nxt.ent[k] = ENT_RST;
      end else begin
        st_nxt.ent[k] = upd[k-1];
      end
    end

    if (ISS_VALID && st_r.ready) begin
      ne.v = 1'b1;
      ne.tag = ISS_TAG;
      ne.kind = cei_kind_t'(ISS_KIND);
      ne.creg = ISS_CREG;
      ne.xw_v = ISS_XW_VALID;
      ne.xw = ISS_XW_REG;
      ne.adw_v = ISS_ADW_VALID;
      ne.adw = ISS_ADW_REG;
    end
    if (st_r.hold[S_D]) begin
      st_nxt.ent[S_D] = upd[S_D];
    end else begin
      st_nxt.ent[S_D] = ne;
    end

    // Hazards depend on pipe contents only, so evaluating them on the
    // next contents and registering gives a hold that is exact for the
    // coming cycle while every output stays a flop.
    st_nxt.hold = hz_if.hold;
    st_nxt.ready = !hz_if.hold[S_D];
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= '0;
      st_r.ready <= 1'b1;
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    ISS_READY = st_r.ready;
    STG_HOLD = st_r.hold;
    OP_FIRE = st_r.fire;
    OP_KILL = st_r.kill;
    OP_TAG = st_r.ftag;
    COND_STROBE = st_r.cstb;
    COND_VALUE = st_r.cval;
    COND_TAG = st_r.ctag;
    for (int k = 0; k < NSTG; k++) begin
      STG_VALID[k] = st_r.ent[k].v;
    end
  end

endmodule

// ===== src/cei_pkg.sv
package cei_pkg;

  localparam int NSTG = 7;
  localparam int TAGW = 4;
  localparam int REGW = 4;

  // Stage indices, youngest first.
  localparam int S_D = 0;
  localparam int S_AD = 1;
  localparam int S_AC1 = 2;
  localparam int S_AC2 = 3;
  localparam int S_R = 4;
  localparam int S_X = 5;
  localparam int S_W = 6;

  // Stall lengths that the interlocks produce in the plain case.
  localparam int STALL_READ_TEST = 1;
  localparam int STALL_WHOLE_TEST = 4;
  localparam int STALL_AD_AFTER_GUARD = 2;

  typedef enum logic [2:0] {
    K_NONE = 3'h0,
    K_COND_R = 3'h1,
    K_WHOLE = 3'h2,
    K_PART = 3'h3,
    K_PART_WR = 3'h4,
    K_RPT = 3'h5
  } cei_kind_t;

  typedef struct packed {
    logic v;
    logic [TAGW-1:0] tag;
    cei_kind_t kind;
    logic [REGW-1:0] creg;
    logic xw_v;
    logic [REGW-1:0] xw;
    logic adw_v;
    logic [REGW-1:0] adw;
    logic cdone;
    logic cok;
  } cei_ent_t;

  typedef cei_ent_t [NSTG-1:0] cei_pipe_t;

  localparam cei_ent_t ENT_RST = '0;

  // Stage in which the condition of each kind is sampled.
  function automatic int eval_stage(cei_kind_t k);
    int s;
    s = -1;
    unique case (k)
      K_COND_R: s = S_R;
      K_WHOLE: s = S_AD;
      K_PART: s = S_X;
      K_PART_WR: s = S_R;
      K_RPT: s = S_X;
      default: s = -1;
    endcase
    return s;
  endfunction

endpackage

// ===== src/cei_stg_if.sv
`timescale 1ns/1ps
interface cei_stg_if;
  import cei_pkg::*;
  cei_pipe_t ent;
  logic [NSTG-1:0] hold;
  modport core (output ent, input hold);
  modport mon (input ent, output hold);
endinterface
